// ### bench/smio_host_model.sv
// Host master: mode 0 clock, idle low between frames
module smio_host_model (
  // Link pins
  output logic sclk,
  output logic selN,
  output logic [3:0] hOut,
  output logic [3:0] hOeN
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    hOut = 4'h0;
    hOeN = 4'hf;
  end
  task sel(input logic v);
    selN = v;
    #40;
  endtask
  task drive(input logic [3:0] d, input logic [3:0] oe);
    hOut = d;
    hOeN = oe;
  endtask
  // 64 ns period, so the block sees every edge
  task half(input logic v);
    sclk = v;
    #32;
  endtask
endmodule

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smio_pkg::*;
  logic clk, reset, sclk, selN, rxReady, txValid, instrPhase, outPhase;
  logic regWriteCmd, busyIn, rxValid, txReady, active, standby, armed;
  logic writeProtectN, hwResetReq, regWriteBlock, writeInProgress;
  logic [3:0] hOut, hOeN, lanes, lanePinOut, lanePinOeN, rxBits, txBits;
  smio_cfg_type cfg;
  smio_width_type width;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [16:0] rxTab [5];
  // Floating lanes 0,1 show the inverse; lanes 2,3 have pull-ups
  assign lanes = (~lanePinOeN & lanePinOut) | (lanePinOeN & ~hOeN & hOut)
    | (lanePinOeN & hOeN & {2'h3, ~hOut[1:0]});
  smio_host_model host (.sclk(sclk), .selN(selN), .hOut(hOut), .hOeN(hOeN));
  smio_pin_if uut (.clk(clk), .reset(reset), .sclkPin(sclk),
    .selectNPin(selN), .lanePinIn(lanes), .lanePinOut(lanePinOut),
    .lanePinOeN(lanePinOeN), .cfg(cfg), .instrPhase(instrPhase),
    .outPhase(outPhase), .width(width), .regWriteCmd(regWriteCmd),
    .busyIn(busyIn), .rxValid(rxValid), .rxBits(rxBits),
    .rxReady(rxReady), .txValid(txValid), .txBits(txBits),
    .txReady(txReady), .active(active), .standby(standby), .armed(armed),
    .writeProtectN(writeProtectN), .hwResetReq(hwResetReq),
    .regWriteBlock(regWriteBlock), .writeInProgress(writeInProgress));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ****************
  // Helpers
  // ****************
  task check(input string nm, input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Request held until the buffer has room
  task push(input logic [3:0] d);
    @(negedge clk);
    txValid = 1'b1;
    txBits = d;
    while (!txReady) @(negedge clk);
    @(negedge clk);
    txValid = 1'b0;
  endtask
  // Held word survives a stalled receiver
  task rx(input logic [3:0] d, input logic [3:0] e, input logic [3:0] m);
    host.drive(d, 4'h0);
    host.half(1'b1);
    host.half(1'b0);
    check("rxValid", {3'h0, rxValid}, 4'h1);
    check("rxBits", rxBits & m, e & m);
    @(negedge clk) rxReady = 1'b1;
    @(negedge clk) rxReady = 1'b0;
  endtask
  task shift(input logic [3:0] e);
    host.half(1'b1);
    host.half(1'b0);
    check("lanes", lanes, e);
  endtask
  // Mode and phase inputs; caller applies them at a falling edge
  task mode(input logic q, input logic an, input logic ip, input logic op,
    input logic dr, input smio_width_type w);
    cfg.quad = q;
    cfg.allNibbleMode = an;
    instrPhase = ip;
    outPhase = op;
    cfg.ddr = dr;
    width = w;
  endtask
  task ctl(input logic rw, input logic bz, input logic swd, input logic re);
    regWriteCmd = rw;
    busyIn = bz;
    cfg.statusWriteDisable = swd;
    cfg.resetEnable = re;
  endtask
  // ****************
  // Stimulus
  // ****************
  initial begin
    reset = 1'b1;
    rxReady = 1'b0;
    txValid = 1'b0;
    txBits = 4'h0;
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SMIO_W1);
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    rxTab = '{{4'h1, 4'h1, 4'h1, 3'h1, 2'h0}, {4'he, 4'h0, 4'h1, 3'h5, 2'h2},
      {4'h6, 4'h2, 4'h3, 3'h0, 2'h1}, {4'ha, 4'ha, 4'hf, 3'h4, 2'h2},
      {4'h5, 4'h5, 4'hf, 3'h3, 2'h2}};
    repeat (10) @(negedge clk);
    reset = 1'b0;
    host.half(1'b1);
    host.half(1'b0);
    check("armed", {3'h0, armed}, 4'h0);
    check("rxValid", {3'h0, rxValid}, 4'h0);
    check("oeN", lanePinOeN, 4'hf);
    host.sel(1'b0);
    check("active", {3'h0, active}, 4'h1);
    check("standby", {3'h0, standby}, 4'h0);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      mode(rxTab[i][4], rxTab[i][3], rxTab[i][2], 1'b0, 1'b0,
        smio_width_type'(rxTab[i][1:0]));
      rx(rxTab[i][16:13], rxTab[i][12:9], rxTab[i][8:5]);
    end
    $display("test receive done"); // above
    @(negedge clk);
    mode(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, SMIO_W4);
    host.drive(4'h0, 4'hf);
    push(4'h9);
    push(4'h6);
    // Two words held: buffer full, further pushes refused
    check("txReady", {3'h0, txReady}, 4'h0);
    shift(4'h9);
    check("oeN", lanePinOeN, 4'h0);
    host.half(1'b1);
    check("lanes", lanes, 4'h9);
    host.half(1'b0);
    check("lanes", lanes, 4'h6);
    shift(4'h6);
    @(negedge clk);
    mode(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, SMIO_W4);
    push(4'h3);
    push(4'hc);
    host.half(1'b1);
    check("lanes", lanes, 4'h3);
    host.half(1'b0);
    check("lanes", lanes, 4'hc);
    @(negedge clk);
    mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, SMIO_W1);
    // Bit 0 low: lane1 driven low, lane0 floats high, 2 and 3 pulled up
    push(4'he);
    shift(4'hd);
    check("oeN", lanePinOeN, 4'hd);
    check("lane1", {3'h0, lanes[1]}, 4'h0);
    @(negedge clk);
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SMIO_W1);
    host.sel(1'b1);
    check("oeN", lanePinOeN, 4'hf);
    check("standby", {3'h0, standby}, 4'h1);
    @(negedge clk);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    check("standby", {3'h0, standby}, 4'h0);
    check("wip", {3'h0, writeInProgress}, 4'h1);
    $display("test transmit and select done");
    @(negedge clk);
    ctl(1'b1, 1'b0, 1'b1, 1'b0);
    host.drive(4'h0, 4'hb);
    repeat (5) @(negedge clk);
    check("wpN", {3'h0, writeProtectN}, 4'h0);
    check("block", {3'h0, regWriteBlock}, 4'h1);
    @(negedge clk);
    mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, SMIO_W1);
    repeat (3) @(negedge clk);
    check("block", {3'h0, regWriteBlock}, 4'h0);
    check("wpN", {3'h0, writeProtectN}, 4'h1);
    @(negedge clk);
    ctl(1'b0, 1'b0, 1'b1, 1'b1);
    mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SMIO_W1);
    host.drive(4'h0, 4'h7);
    repeat (5) @(negedge clk);
    check("rst", {3'h0, hwResetReq}, 4'h1);
    @(negedge clk);
    mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, SMIO_W1);
    repeat (3) @(negedge clk);
    check("rst", {3'h0, hwResetReq}, 4'h1);
    host.sel(1'b0);
    check("rst", {3'h0, hwResetReq}, 4'h0);
    host.sel(1'b1);
    @(negedge clk);
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clk);
    check("rst", {3'h0, hwResetReq}, 4'h0);
    $display("test shared pins done");
    stop_test();
  end
endmodule

// ### hdl/smio_pin_if.sv
`include "smio_regs.svh"
module smio_pin_if #(
  parameter int LANES = `SMIO_LANES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link pins
  input wire logic sclkPin,
  input wire logic selectNPin,
  input wire logic [3:0] lanePinIn,
  output logic [3:0] lanePinOut,
  output logic [3:0] lanePinOeN,
  // Configuration from command logic
  input smio_pkg::smio_cfg_type cfg,
  input wire logic instrPhase,
  input wire logic outPhase,
  input smio_pkg::smio_width_type width,
  input wire logic regWriteCmd,
  input wire logic busyIn,
  // Received bits
  output logic rxValid,
  output logic [3:0] rxBits,
  input wire logic rxReady,
  // Transmit bits
  input wire logic txValid,
  input wire logic [3:0] txBits,
  output logic txReady,
  // Status
  output logic active,
  output logic standby,
  output logic armed,
  output logic writeProtectN,
  output logic hwResetReq,
  output logic regWriteBlock,
  output logic writeInProgress
);
  import smio_pkg::*;

  if (LANES != 4) begin : gLaneCheck
    $error("smio_pin_if serves four lanes only");
  end

  // ********************************
  // Input synchronisers
  // ********************************
  logic [5:0] syncA_reg, syncA_next, syncB_reg, syncB_next;
  logic sckD_reg, sckD_next, csD_reg, csD_next;
  always_comb begin
    syncA_next = {sclkPin, selectNPin, lanePinIn};
    syncB_next = syncA_reg;
    sckD_next = syncB_reg[5];
    csD_next = syncB_reg[4];
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      // Idle levels, so no false protect or reset right after reset
      syncA_reg <= `SMIO_SYNC_RST;
      syncB_reg <= `SMIO_SYNC_RST;
      sckD_reg <= 1'b0;
      csD_reg <= 1'b1;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      sckD_reg <= sckD_next;
      csD_reg <= csD_next;
    end
  end

  logic sck, csN, riseEdge, fallEdge, csFall;
  logic [3:0] lanes;
  assign sck = syncB_reg[5];
  assign csN = syncB_reg[4];
  assign lanes = syncB_reg[3:0];
  assign riseEdge = sck & ~sckD_reg;
  assign fallEdge = ~sck & sckD_reg;
  assign csFall = ~csN & csD_reg;

  // ********************************
  // Selection and power state
  // ********************************
  logic armed_reg, armed_next;
  always_comb begin
    armed_next = armed_reg;
    if (csFall) begin
      armed_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end
  assign armed = armed_reg;
  assign active = ~csN & armed_reg;
  assign standby = csN & ~busyIn;
  assign writeInProgress = busyIn;

  // ********************************
  // Shared pin roles
  // ********************************
  logic wpRole, rstRole;
  assign wpRole = ~cfg.quad & cfg.statusWriteDisable;
  assign writeProtectN = wpRole ? lanes[2] : 1'b1;
  assign regWriteBlock = regWriteCmd & wpRole & ~lanes[2];
  assign rstRole = cfg.resetEnable & (~cfg.quad | csN);
  assign hwResetReq = rstRole & ~lanes[3];

  // ********************************
  // Receive path
  // ********************************
  smio_width_type effW;
  always_comb begin
    if (cfg.allNibbleMode) begin
      effW = SMIO_W4;
    end else if (instrPhase) begin
      effW = SMIO_W1;
    end else begin
      effW = width;
    end
  end

  logic [3:0] rxBits_reg, rxBits_next;
  logic rxValid_reg, rxValid_next;
  logic sampleEdge;
  assign sampleEdge = active & ~outPhase &
                      (riseEdge | (cfg.ddr & ~instrPhase & fallEdge));
  always_comb begin
    rxBits_next = rxBits_reg;
    rxValid_next = rxValid_reg & ~rxReady;
    if (sampleEdge) begin
      rxValid_next = 1'b1;
      case (effW)
        SMIO_W1: rxBits_next = {3'h0, lanes[0]};
        SMIO_W2: rxBits_next = {2'h0, lanes[1:0]};
        SMIO_W4: rxBits_next = cfg.quad | cfg.allNibbleMode ?
                               lanes : {2'h0, lanes[1:0]};
        default: rxBits_next = 4'h0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rxBits_reg <= `SMIO_BITS_RST;
      rxValid_reg <= 1'b0;
    end else begin
      rxBits_reg <= rxBits_next;
      rxValid_reg <= rxValid_next;
    end
  end
  assign rxBits = rxBits_reg;
  assign rxValid = rxValid_reg;

  // ********************************
  // Two-entry transmit buffer
  // ********************************
  logic [3:0] buf0_reg, buf0_next, buf1_reg, buf1_next;
  logic [1:0] cnt_reg, cnt_next;
  logic popWord;
  assign txReady = cnt_reg != 2'd2;
  always_comb begin
    buf0_next = buf0_reg;
    buf1_next = buf1_reg;
    cnt_next = cnt_reg;
    if (popWord) begin
      buf0_next = buf1_reg;
      cnt_next = cnt_next - 2'd1;
    end
    if (txValid && txReady) begin
      if (cnt_next == 2'd0) begin
        buf0_next = txBits;
      end else begin
        buf1_next = txBits;
      end
      cnt_next = cnt_next + 2'd1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      buf0_reg <= `SMIO_BITS_RST;
      buf1_reg <= `SMIO_BITS_RST;
      cnt_reg <= 2'd0;
    end else begin
      buf0_reg <= buf0_next;
      buf1_reg <= buf1_next;
      cnt_reg <= cnt_next;
    end
  end

  // ********************************
  // Output drive
  // ********************************
  logic [3:0] out_reg, out_next, oeN_reg, oeN_next;
  logic shiftEdge;
  assign shiftEdge = active & outPhase & (fallEdge | (cfg.ddr & riseEdge));
  // Stale data rather than a gap when the buffer runs dry
  assign popWord = shiftEdge & (cnt_reg != 2'd0);
  always_comb begin
    out_next = out_reg;
    oeN_next = oeN_reg;
    if (!active || !outPhase) begin
      oeN_next = `SMIO_OE_N_RST;
    end else if (shiftEdge) begin
      out_next = buf0_reg;
      case (effW)
        SMIO_W1: begin
          out_next = {2'h0, buf0_reg[0], 1'b0};
          oeN_next = 4'hd;
        end
        SMIO_W2: oeN_next = 4'hc;
        SMIO_W4: oeN_next = 4'h0;
        default: oeN_next = `SMIO_OE_N_RST;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      out_reg <= `SMIO_BITS_RST;
      oeN_reg <= `SMIO_OE_N_RST;
    end else begin
      out_reg <= out_next;
      oeN_reg <= oeN_next;
    end
  end
  assign lanePinOut = out_reg;
  assign lanePinOeN = oeN_reg;

  // ********************************
  // Assertions
  // ********************************
  deselect_float_a:
    assert property (@(posedge clk) disable iff (reset)
      csN |=> lanePinOeN == 4'hf)
    else $error("Lanes driven while deselected");
  arm_needed_a:
    assert property (@(posedge clk) disable iff (reset)
      !armed |-> !active)
    else $error("Active before select fall");
  protect_block_a:
    assert property (@(posedge clk) disable iff (reset)
      (regWriteCmd && !cfg.quad && cfg.statusWriteDisable && !lanes[2])
      |-> regWriteBlock)
    else $error("Protected write not blocked");
  reset_role_a:
    assert property (@(posedge clk) disable iff (reset)
      hwResetReq |-> cfg.resetEnable && (!cfg.quad || csN))
    else $error("Reset seen in wrong role");
  reset_off_a:
    assert property (@(posedge clk) disable iff (reset)
      !cfg.resetEnable |-> !hwResetReq)
    else $error("Reset with feature off");
  sample_rise_a:
    assert property (@(posedge clk) disable iff (reset)
      (active && !outPhase && !cfg.ddr && riseEdge) |=> rxValid)
    else $error("Rising edge not sampled");
  single_out_a:
    assert property (@(posedge clk) disable iff (reset)
      (shiftEdge && effW == SMIO_W1 && !csN && outPhase)
      |=> lanePinOeN == 4'hd)
    else $error("Single output not on lane one");
  no_input_drive_a:
    assert property (@(posedge clk) disable iff (reset)
      !outPhase |=> lanePinOeN == 4'hf)
    else $error("Lane driven outside output phase");
  standby_a:
    assert property (@(posedge clk) disable iff (reset)
      busyIn |-> !standby && writeInProgress)
    else $error("Standby while busy");
endmodule

// ### pkg/smio_pkg.sv
`include "smio_regs.svh"
package smio_pkg;
  // Lane width of the current phase
  typedef enum logic [1:0] {
    SMIO_W1 = 2'b00,
    SMIO_W2 = 2'b01,
    SMIO_W4 = 2'b10
  } smio_width_type;

  // Pin triplet of the four lanes
  typedef struct packed {
    logic [3:0] in;
    logic [3:0] out;
    logic [3:0] oeN;
  } smio_pins_type;

  // Mode and configuration bits
  typedef struct packed {
    logic quad;
    logic statusWriteDisable;
    logic resetEnable;
    logic allNibbleMode;
    logic ddr;
  } smio_cfg_type;

  typedef enum logic [1:0] {
    SMIO_IDLE = 2'b00,
    SMIO_IN = 2'b01,
    SMIO_OUT = 2'b10
  } smio_state_type;
endpackage

// ### pkg/smio_regs.svh
`ifndef SMIO_REGS_SVH
`define SMIO_REGS_SVH
// ********************************
// Field positions
// ********************************
`define SMIO_QUAD_BIT 1
`define SMIO_SRWD_BIT 7
`define SMIO_RSTEN_BIT 5
// ********************************
// Reset values and widths
// ********************************
`define SMIO_LANES 4
`define SMIO_BITS_RST 4'h0
`define SMIO_OE_N_RST 4'hf
// Idle pin levels: clock low, deselected, lanes 2 and 3 pulled up
`define SMIO_SYNC_RST 6'h1c
`endif
